// ---- inc/rmmc_pkg.sv ----
package rmmc_pkg;

  // operating modes of the chip as seen by the regulators
  typedef enum logic [2:0] {
    RMMC_NORMAL,
    RMMC_STOP,
    RMMC_SLEEP,
    RMMC_FAILSAFE,
    RMMC_RESTART
  } rmmc_mode_e;

  // hardware_control bits that steer the regulators
  typedef struct packed {
    logic auto_pwm_en;   // current-triggered pfm to pwm allowed
    logic lag_long;      // 1: long lag time, 0: short lag time
    logic boost_en;      // step-up converter enabled
    logic boost_vsel;    // step-up output level select
    logic wake_mod_sel;  // wake_pin_modulation_select
  } rmmc_hardware_control_s;

  // raw step-up pin fault detectors
  typedef struct packed {
    logic gnd_loss;
    logic pin_short;
    logic pin_open;
  } rmmc_bst_flt_s;

  localparam rmmc_mode_e    MODE_RST    = RMMC_RESTART;
  localparam rmmc_hardware_control_s HARDWARE_CONTROL_RST = 5'h00;

  // converter_status field positions
  localparam int unsigned STAT_W        = 3;
  localparam int unsigned STAT_OPEN_BIT = 0;
  localparam int unsigned STAT_SHRT_BIT = 1;
  localparam int unsigned STAT_GND_BIT  = 2;
  localparam logic [STAT_W-1:0] STAT_RST = 3'h0;

  // modulation lag time
  localparam int unsigned CLK_FREQ_MHZ  = 200;
  localparam int unsigned TLAG_LONG_US  = 1000;
  localparam int unsigned TLAG_SHORT_US = 100;
  localparam int unsigned TLAG_LONG_CYC  = TLAG_LONG_US * CLK_FREQ_MHZ;
  localparam int unsigned TLAG_SHORT_CYC = TLAG_SHORT_US * CLK_FREQ_MHZ;
  localparam int unsigned LAG_CW = 18;

endpackage

// ---- core/rmmc_lag_timer.sv ----
`timescale 1ns/10ps
module rmmc_lag_timer #(
  parameter int unsigned CW = 18,
  parameter logic [CW-1:0] TERM_LONG  = 18'h30D40,
  parameter logic [CW-1:0] TERM_SHORT = 18'h04E20
) (
  input  wire logic sys_clk_i,   // system clock
  input  wire logic rst_i,       // sync reset, active high
  input  wire logic run_i,       // count while high, clear when low
  input  wire logic sel_long_i,  // pick long terminal count
  output logic      done_o       // lag elapsed
);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] term;

  assign term   = sel_long_i ? TERM_LONG : TERM_SHORT;
  assign done_o = run_i && (cnt_reg >= term);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !run_i)
      cnt_reg <= '0;
    else if (cnt_reg < term)
      cnt_reg <= cnt_reg + 1'b1;
  end

endmodule // rmmc_lag_timer

// ---- core/rmmc_boost_ctrl.sv ----
`timescale 1ns/10ps
module rmmc_boost_ctrl (
  input  wire logic sys_clk_i,  // system clock
  input  wire logic rst_i,      // sync reset, active high
  input  wire logic en_i,       // enabled and mode allows it
  input  wire logic below_i,    // supply below selected threshold
  input  wire logic above_i,    // supply above threshold plus hysteresis
  input  wire logic oc_i,       // shunt overcurrent comparator
  output logic      run_o,      // step-up switching
  output logic      cut_o       // shorten duty cycle
);

  logic run_reg;
  logic cut_reg;

  assign run_o = run_reg;
  assign cut_o = cut_reg;

  // switching is always fixed-frequency pwm, there is no pfm path
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !en_i)
      run_reg <= 1'b0;
    else if (below_i)
      run_reg <= 1'b1;
    else if (above_i)
      run_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      cut_reg <= 1'b0;
    else
      cut_reg <= en_i && run_reg && oc_i;
  end

endmodule // rmmc_boost_ctrl

// ---- core/rmmc_core.sv ----
`timescale 1ns/10ps
module rmmc_core
  import rmmc_pkg::*;
#(
  parameter int unsigned LAG_LONG_CYC  = rmmc_pkg::TLAG_LONG_CYC,
  parameter int unsigned LAG_SHORT_CYC = rmmc_pkg::TLAG_SHORT_CYC
) (
  input  wire logic                   sys_clk_i,           // system clock
  input  wire logic                   rst_i,               // sync reset
  input  wire logic                   mode_cmd_valid_i,    // mode command written
  input  wire rmmc_pkg::rmmc_mode_e   mode_cmd_i,          // requested mode
  input  wire rmmc_pkg::rmmc_hardware_control_s hardware_control_i, // control bits
  input  wire logic                   wake_event_i,        // filtered wake-up
  input  wire logic                   wake_input_i,        // raw wake level
  input  wire logic                   over_pfm_exit_i,     // load above exit
  input  wire logic                   vcc_above_rst_i,     // above reset level
  input  wire logic                   vsense_below_i,      // below step-up on
  input  wire logic                   vsense_above_i,      // above off level
  input  wire logic                   shunt_oc_i,          // shunt overcurrent
  input  wire rmmc_pkg::rmmc_bst_flt_s bst_fault_i,        // pin faults
  input  wire logic [rmmc_pkg::STAT_W-1:0] status_clr_i,   // status clear
  input  wire logic                   auto_flag_clr_i,     // flag clear
  output rmmc_pkg::rmmc_mode_e        mode_o,              // current mode
  output logic                        buck_en_o,           // step-down on
  output logic                        buck_pwm_o,          // 1 pwm, 0 pfm
  output logic                        boost_run_o,         // step-up switching
  output logic                        boost_vsel_o,        // step-up level
  output logic                        boost_cut_o,         // duty reduction
  output logic                        reset_output_n_o,    // reset, low active
  output logic                        int_req_o,           // interrupt pulse
  output logic                        auto_switch_flag_o,  // wake_status_one
  output logic [rmmc_pkg::STAT_W-1:0] converter_status_o   // step-up faults
);

  import rmmc_pkg::*;

  rmmc_mode_e    mode_reg;
  rmmc_mode_e    mode_next;
  rmmc_hardware_control_s cfg_held_reg;
  rmmc_hardware_control_s cfg;
  logic          active;
  logic          boost_mode_ok;
  logic          auto_pwm_reg;
  logic          pfm_req;
  logic          lag_done;
  logic          auto_trig;
  logic          stop_cmd;
  logic          buck_en_reg;
  logic          buck_pwm_reg;
  logic          buck_pwm_next;
  logic          vsel_reg;
  logic          rst_out_n_reg;
  logic          int_req_reg;
  logic          flag_reg;
  logic [STAT_W-1:0] stat_reg;
  logic [STAT_W-1:0] stat_set;

  ////////////////////////////////////////////////////////////////////////
  // mode sequencing

  assign stop_cmd = mode_cmd_valid_i && (mode_cmd_i == RMMC_STOP);

  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      RMMC_NORMAL,
      RMMC_STOP:
      begin
        if (mode_cmd_valid_i && (mode_cmd_i != RMMC_RESTART))
          mode_next = mode_cmd_i;
      end
      RMMC_SLEEP,
      RMMC_FAILSAFE:
      begin
        if (wake_event_i)
          mode_next = RMMC_RESTART;
      end
      RMMC_RESTART:
      begin
        if (vcc_above_rst_i)
          mode_next = RMMC_NORMAL;
      end
      default:
      begin
        mode_next = MODE_RST;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      mode_reg <= MODE_RST;
    else
      mode_reg <= mode_next;
  end

  assign mode_o = mode_reg;
  assign active = (mode_reg == RMMC_NORMAL) || (mode_reg == RMMC_STOP);

  ////////////////////////////////////////////////////////////////////////
  // configuration: live in normal/stop, held copy elsewhere

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      cfg_held_reg <= HARDWARE_CONTROL_RST;
    else if (active)
      cfg_held_reg <= hardware_control_i;
  end

  assign cfg = active ? hardware_control_i : cfg_held_reg;

  ////////////////////////////////////////////////////////////////////////
  // step-down modulation

  // pfm wanted: stop, no forced pwm, wake pin not asking for pwm
  assign pfm_req = (mode_reg == RMMC_STOP) && !auto_pwm_reg
                && !(cfg.wake_mod_sel && wake_input_i);

  // restarts from zero each time pfm is requested again
  rmmc_lag_timer #(
    .CW         (LAG_CW),
    .TERM_LONG  (LAG_CW'(LAG_LONG_CYC)),
    .TERM_SHORT (LAG_CW'(LAG_SHORT_CYC))
  ) u_lag (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .run_i      (pfm_req),
    .sel_long_i (cfg.lag_long),
    .done_o     (lag_done)
  );

  assign auto_trig = pfm_req && lag_done && cfg.auto_pwm_en
                  && over_pfm_exit_i;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      auto_pwm_reg <= 1'b0;
    else if (mode_next != RMMC_STOP)
      auto_pwm_reg <= 1'b0;
    else if (auto_trig)
      auto_pwm_reg <= 1'b1;
    else if (stop_cmd)
      auto_pwm_reg <= 1'b0;
  end

  always_comb
  begin
    case (mode_reg)
      RMMC_NORMAL,
      RMMC_RESTART:
        buck_pwm_next = 1'b1;
      RMMC_STOP:
        buck_pwm_next = !(pfm_req && lag_done);
      default:
        buck_pwm_next = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      buck_pwm_reg <= 1'b1;
    else
      buck_pwm_reg <= buck_pwm_next;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      buck_en_reg <= 1'b1;
    else
      buck_en_reg <= active || (mode_reg == RMMC_RESTART);
  end

  assign buck_en_o  = buck_en_reg;
  assign buck_pwm_o = buck_pwm_reg;

  ////////////////////////////////////////////////////////////////////////
  // step-up converter

  assign boost_mode_ok = active || (mode_reg == RMMC_RESTART);

  // mode changes between normal and stop do not touch the enable
  rmmc_boost_ctrl u_boost (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .en_i      (cfg.boost_en && boost_mode_ok),
    .below_i   (vsense_below_i),
    .above_i   (vsense_above_i),
    .oc_i      (shunt_oc_i),
    .run_o     (boost_run_o),
    .cut_o     (boost_cut_o)
  );

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      vsel_reg <= 1'b0;
    else
      vsel_reg <= cfg.boost_vsel;
  end

  assign boost_vsel_o = vsel_reg;

  ////////////////////////////////////////////////////////////////////////
  // reset output

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      rst_out_n_reg <= 1'b0;
    else
      rst_out_n_reg <= (mode_next != RMMC_RESTART);
  end

  assign reset_output_n_o = rst_out_n_reg;

  ////////////////////////////////////////////////////////////////////////
  // interrupt request and automatic-switch flag

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      int_req_reg <= 1'b0;
    else
      int_req_reg <= auto_trig;
  end

  // a new switch wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      flag_reg <= 1'b0;
    else
      flag_reg <= auto_trig || (flag_reg && !auto_flag_clr_i);
  end

  assign int_req_o          = int_req_reg;
  assign auto_switch_flag_o = flag_reg;

  ////////////////////////////////////////////////////////////////////////
  // converter_status: reporting only, feeds nothing else

  always_comb
  begin
    stat_set = '0;
    stat_set[STAT_OPEN_BIT] = bst_fault_i.pin_open;
    stat_set[STAT_SHRT_BIT] = bst_fault_i.pin_short;
    stat_set[STAT_GND_BIT]  = bst_fault_i.gnd_loss;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      stat_reg <= STAT_RST;
    else
      stat_reg <= stat_set | (stat_reg & ~status_clr_i);
  end

  assign converter_status_o = stat_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_normal_pwm: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (mode_reg == RMMC_NORMAL) |=> buck_pwm_o && buck_en_o)
    else $error("step-down not in pwm in normal mode");

  a_sleep_off: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ((mode_reg == RMMC_SLEEP) || (mode_reg == RMMC_FAILSAFE))
      |=> !buck_en_o && !boost_run_o)
    else $error("converter running in sleep or fail-safe");

  a_lag_hold: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $rose(pfm_req) |=> buck_pwm_o [*2])
    else $error("pfm entered before lag time");

  a_auto_switch: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    auto_trig |=> int_req_o && auto_switch_flag_o && auto_pwm_reg
                  ##1 buck_pwm_o)
    else $error("automatic switch not reported or applied");

  a_int_pulse: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    int_req_o |=> !int_req_o)
    else $error("interrupt request longer than one cycle");

  a_flag_sticky: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    auto_switch_flag_o && !auto_flag_clr_i |=> auto_switch_flag_o)
    else $error("automatic-switch flag dropped without clear");

  a_auto_off: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !cfg.auto_pwm_en && !auto_pwm_reg |=> !auto_pwm_reg)
    else $error("automatic switch with auto enable low");

  a_pfm_restore: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    auto_pwm_reg && !stop_cmd && (mode_next == RMMC_STOP)
      |=> auto_pwm_reg)
    else $error("pfm restored without stop command");

  a_wake_pwm: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (mode_reg == RMMC_STOP) && cfg.wake_mod_sel && wake_input_i
      |=> buck_pwm_o)
    else $error("wake pin high did not select pwm");

  a_wake_restart: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ((mode_reg == RMMC_SLEEP) || (mode_reg == RMMC_FAILSAFE))
      && wake_event_i |=> (mode_reg == RMMC_RESTART) && !reset_output_n_o)
    else $error("wake-up did not enter restart");

  a_reset_held: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (mode_reg == RMMC_RESTART) && !vcc_above_rst_i |=> !reset_output_n_o)
    else $error("reset output released during restart");

  a_reset_release: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (mode_reg == RMMC_RESTART) && vcc_above_rst_i
      |=> reset_output_n_o && (mode_reg == RMMC_NORMAL))
    else $error("reset output not released above threshold");

  a_status_set: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    bst_fault_i.gnd_loss |=> converter_status_o[STAT_GND_BIT])
    else $error("ground loss not flagged");

endmodule // rmmc_core

// ---- test/rmmc_mcu_model.sv ----
`timescale 1ns/10ps
module rmmc_mcu_model
  import rmmc_pkg::*;
(
  input  wire logic                sys_clk_i,  // system clock
  output logic                     cmd_vld_o,  // mode command strobe
  output rmmc_pkg::rmmc_mode_e     cmd_o,      // mode code
  output rmmc_pkg::rmmc_hardware_control_s  ctrl_o,     // control bits
  output logic                     wake_o,     // wake pin level
  output logic                     wake_ev_o,  // filtered wake-up event
  output logic                     flag_clr_o, // auto_switch_flag clear
  output logic [rmmc_pkg::STAT_W-1:0] stat_clr_o // converter_status clear
);
  initial
  begin
    cmd_vld_o = 1'b0;
    cmd_o = RMMC_NORMAL;
    ctrl_o = HARDWARE_CONTROL_RST;
    wake_o = 1'b0;
    wake_ev_o = 1'b0;
    flag_clr_o = 1'b0;
    stat_clr_o = STAT_RST;
  end

  // one-cycle wake event and clear strobes, launched like a command write
  task automatic pulse(input logic wk, input logic fc, input logic [STAT_W-1:0] sc);
    @(negedge sys_clk_i);
    wake_ev_o = wk;
    flag_clr_o = fc;
    stat_clr_o = sc;
    @(negedge sys_clk_i);
    wake_ev_o = 1'b0;
    flag_clr_o = 1'b0;
    stat_clr_o = STAT_RST;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle command write launched off the falling edge
  task automatic send(input rmmc_mode_e m);
    @(negedge sys_clk_i);
    cmd_o = m;
    cmd_vld_o = 1'b1;
    @(negedge sys_clk_i);
    cmd_vld_o = 1'b0;
  endtask

  task automatic set_ctrl(input rmmc_hardware_control_s c);
    @(negedge sys_clk_i);
    ctrl_o = c;
  endtask

  // clean level, no bounce, since the pin is read unfiltered
  task automatic set_wake(input logic b);
    @(negedge sys_clk_i);
    wake_o = b;
  endtask
endmodule // rmmc_mcu_model

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import rmmc_pkg::*;
  localparam int LAG_L = 20;
  localparam int LAG_S = 6;
  localparam rmmc_bst_flt_s FLT_OPEN_GND = 3'h5;
  logic           sys_clk_i, rst_i, wake_ev, over, vabove, vbelow, vhi, shunt;
  logic           flag_clr, cmd_vld, wake_pin;
  logic           buck_en, buck_pwm, bst_run, bst_vsel, bst_cut, rst_n, int_req, flag;
  logic [2:0]     stat_clr, stat;
  rmmc_bst_flt_s  bst_flt;
  rmmc_hardware_control_s  ctrl;
  rmmc_mode_e     cmd, mode;
  int             err_total, checks_done, cyc_cnt;

  rmmc_mcu_model mcu (.sys_clk_i(sys_clk_i), .cmd_vld_o(cmd_vld), .cmd_o(cmd),
    .ctrl_o(ctrl), .wake_o(wake_pin), .wake_ev_o(wake_ev), .flag_clr_o(flag_clr),
    .stat_clr_o(stat_clr));

  rmmc_core #(.LAG_LONG_CYC(LAG_L), .LAG_SHORT_CYC(LAG_S)) dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .mode_cmd_valid_i(cmd_vld),
    .mode_cmd_i(cmd), .hardware_control_i(ctrl), .wake_event_i(wake_ev),
    .wake_input_i(wake_pin), .over_pfm_exit_i(over), .vcc_above_rst_i(vabove),
    .vsense_below_i(vbelow), .vsense_above_i(vhi), .shunt_oc_i(shunt),
    .bst_fault_i(bst_flt), .status_clr_i(stat_clr), .auto_flag_clr_i(flag_clr),
    .mode_o(mode), .buck_en_o(buck_en), .buck_pwm_o(buck_pwm),
    .boost_run_o(bst_run), .boost_vsel_o(bst_vsel), .boost_cut_o(bst_cut),
    .reset_output_n_o(rst_n), .int_req_o(int_req), .auto_switch_flag_o(flag),
    .converter_status_o(stat));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // cycles until buck_pwm reaches v, 99 when it never does
  task automatic wait_pwm(input logic v, output int n);
    n = 0;
    while (buck_pwm !== v && n < 99)
    begin
      cyc(1);
      n++;
    end
  endtask

  task automatic lag_chk(input int lag);
    int n;
    wait_pwm(1'b0, n);
    chk(8'(n >= lag - 1 && n <= lag + 4), 8'h01);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(8'(mode), 8'(RMMC_RESTART));
    chk(8'({rst_n, buck_en, buck_pwm}), 8'h03);
    vabove = 1'b1;
    cyc(3);
    chk(8'(mode), 8'(RMMC_NORMAL));
    chk(8'({rst_n, buck_pwm}), 8'h03);
  endtask

  task automatic t_lag;
    int n;
    mcu.set_ctrl(5'h18);
    mcu.send(RMMC_STOP);
    chk(8'(buck_pwm), 8'h01);
    lag_chk(LAG_L);
    mcu.send(RMMC_NORMAL);
    wait_pwm(1'b1, n);
    chk(8'(n < 4), 8'h01);
    mcu.set_ctrl(5'h10);
    mcu.send(RMMC_STOP);
    lag_chk(LAG_S);
  endtask

  task automatic t_auto;
    int p;
    p = 0;
    over = 1'b1;
    repeat (6)
    begin
      cyc(1);
      p += (int_req === 1'b1);
    end
    chk(8'(p), 8'h01);
    chk(8'({flag, buck_pwm}), 8'h03);
    chk(8'(mode), 8'(RMMC_STOP));
    mcu.pulse(1'b0, 1'b1, 3'h0);
    cyc(1);
    chk(8'(flag), 8'h00);
    over = 1'b0;
    mcu.send(RMMC_STOP);
    lag_chk(LAG_S);
    mcu.set_ctrl(5'h00);
    over = 1'b1;
    p = 0;
    repeat (8)
    begin
      cyc(1);
      p += (int_req === 1'b1);
    end
    chk(8'({p[0], flag, buck_pwm}), 8'h00);
    over = 1'b0;
  endtask

  task automatic t_wake;
    mcu.set_wake(1'b1);
    cyc(4);
    chk(8'(buck_pwm), 8'h00);
    mcu.set_wake(1'b0);
    mcu.set_ctrl(5'h01);
    cyc(3);
    mcu.set_wake(1'b1);
    cyc(2);
    chk(8'(buck_pwm), 8'h01);
    mcu.set_wake(1'b0);
    lag_chk(LAG_S);
  endtask

  task automatic t_boost;
    mcu.set_ctrl(5'h06);
    vbelow = 1'b1;
    cyc(3);
    chk(8'({bst_run, bst_vsel}), 8'h03);
    vbelow = 1'b0;
    shunt = 1'b1;
    cyc(3);
    chk(8'({bst_run, bst_cut, buck_pwm}), 8'h06);
    shunt = 1'b0;
    mcu.send(RMMC_NORMAL);
    cyc(3);
    chk(8'({bst_run, bst_cut, buck_pwm}), 8'h05);
    vhi = 1'b1;
    cyc(2);
    chk(8'(bst_run), 8'h00);
    vhi = 1'b0;
  endtask

  task automatic t_fault;
    bst_flt = FLT_OPEN_GND;
    cyc(1);
    bst_flt = rmmc_bst_flt_s'(STAT_RST);
    cyc(2);
    chk(8'(stat), 8'h05);
    chk(8'(mode), 8'(RMMC_NORMAL));
    mcu.send(RMMC_RESTART);
    cyc(1);
    chk(8'(mode), 8'(RMMC_NORMAL));
    mcu.pulse(1'b0, 1'b0, 3'h1);
    cyc(1);
    chk(8'(stat), 8'h04);
  endtask

  task automatic t_sleep(input rmmc_mode_e m);
    vbelow = 1'b1;
    mcu.send(m);
    vabove = 1'b0;
    cyc(3);
    chk(8'(mode), 8'(m));
    chk(8'({buck_en, bst_run}), 8'h00);
    mcu.send(RMMC_NORMAL);
    cyc(3);
    chk(8'(mode), 8'(m));
    mcu.pulse(1'b1, 1'b0, 3'h0);
    cyc(2);
    chk(8'(mode), 8'(RMMC_RESTART));
    chk(8'({rst_n, buck_en, bst_run}), 8'h03);
    vabove = 1'b1;
    cyc(3);
    chk(8'({rst_n, mode}), 8'({1'b1, RMMC_NORMAL}));
    vbelow = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 5000)
    begin
      err_total++;
      end_of_test();
    end
  end

  initial
  begin
    rst_i = 1'b1;
    {over, vabove, vbelow, vhi, shunt} = 5'h00;
    bst_flt = rmmc_bst_flt_s'(STAT_RST);
    repeat (6) @(negedge sys_clk_i);
    rst_i = 1'b0;
    cyc(1);
    t_reset();
    t_lag();
    t_auto();
    t_wake();
    t_boost();
    t_fault();
    t_sleep(RMMC_SLEEP);
    t_sleep(RMMC_FAILSAFE);
    end_of_test();
  end
endmodule // tb_top
